// *** pkg/timer_pkg.sv ***
// Purpose: Shared constants and types for the dual timer/counter core
// Assumes: clk is the oscillator clock; registers are 8 bits in the low byte of a word
// Notes: Register map is word indexed; byte address is four times the index
package timer_pkg;
  localparam int NUM_CHAN = 2;
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_MODE = 3'h1;
  localparam logic [2:0] IDX_CKCFG = 3'h2;
  localparam logic [2:0] IDX_COUNT_BASE = 3'h3;
  localparam int CTRL_TYPE_POS = 0;
  localparam int CTRL_EDGE_POS = 1;
  localparam int CTRL_RUN_POS = 4;
  localparam int CTRL_OVF_POS = 5;
  localparam int CTRL_STRIDE = 2;
  localparam int MODE_FIELD_W = 4;
  localparam int MODE_SRC_POS = 2;
  localparam int MODE_GATE_POS = 3;
  localparam int CKCFG_X2_POS = 2;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [2:0] CKCFG_RST = 3'h0;
  localparam logic [7:0] COUNT_RST = 8'h00;
  // Pins idle high; synchronisers start there so reset shows no false edge
  localparam logic PIN_IDLE = 1'b1;
  localparam int PER_CYCLE_TIM = 6;
  localparam int OSC_DIV = 2;
  localparam logic [3:0] TICK_SLOW = 4'(PER_CYCLE_TIM * OSC_DIV);
  localparam logic [3:0] TICK_FAST = 4'(PER_CYCLE_TIM);

  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_HOLD = 2'b11
  } count_mode_t;

  typedef struct packed {
    logic gate_enable;
    logic count_src;
    count_mode_t mode_sel;
  } chan_mode_t;

  typedef struct packed {
    logic overflow_flag;
    logic [7:0] count_high_byte;
    logic [7:0] count_low_byte;
  } count_state_t;

  // One count event applied to a channel
  function automatic count_state_t count_step(count_mode_t m, logic [7:0] hi, logic [7:0] lo);
    count_state_t r;
    r.overflow_flag = 1'b0;
    r.count_high_byte = hi;
    r.count_low_byte = lo;
    case (m)
      MODE_13BIT:
      begin
        // Upper three bits ride along untouched
        r.count_low_byte = {lo[7:5], lo[4:0] + 5'h01};
        if (lo[4:0] == 5'h1f)
        begin
          r.count_high_byte = hi + 8'h01;
          r.overflow_flag = (hi == 8'hff);
        end
      end
      MODE_16BIT:
      begin
        {r.count_high_byte, r.count_low_byte} = {hi, lo} + 16'h0001;
        r.overflow_flag = ({hi, lo} == 16'hffff);
      end
      MODE_RELOAD:
      begin
        if (lo == 8'hff)
        begin
          r.count_low_byte = hi;
          r.overflow_flag = 1'b1;
        end
        else
        begin
          r.count_low_byte = lo + 8'h01;
        end
      end
      default:
      begin
        r.overflow_flag = 1'b0;
      end
    endcase
    return r;
  endfunction : count_step
endpackage : timer_pkg

// *** design/dual_timer_counter_core.sv ***
// Purpose: Two channel timer/counter with Avalon-MM register access
// Assumes: clk is the oscillator clock; pins are asynchronous to it
// Notes: Mode 3 holds the count on both channels; one wait cycle per access
`timescale 1ns/1ns
`default_nettype none
module dual_timer_counter_core (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [timer_pkg::NUM_CHAN-1:0] count_pin,
  input wire logic [timer_pkg::NUM_CHAN-1:0] external_gate_input,
  input wire logic [timer_pkg::NUM_CHAN-1:0] irq_ack,
  output logic [timer_pkg::NUM_CHAN-1:0] irq_req
);
  import timer_pkg::*;

  logic waitrequest_ff;
  logic [31:0] readdata_ff;
  logic [7:0] mode_ff;
  logic [2:0] ckcfg_ff;
  logic [NUM_CHAN-1:0] run_ff;
  logic [NUM_CHAN-1:0] type_ff;
  logic [NUM_CHAN-1:0] edge_ff;
  logic [NUM_CHAN-1:0] ovf_ff;
  logic [7:0] low_ff [NUM_CHAN];
  logic [7:0] high_ff [NUM_CHAN];
  logic [2:0] cnt_sync_ff [NUM_CHAN];
  logic [2:0] gate_sync_ff [NUM_CHAN];
  logic [NUM_CHAN-1:0] cnt_lvl_ff;
  logic [NUM_CHAN-1:0] gate_lvl_ff;
  logic [NUM_CHAN-1:0] gate_prev_ff;
  logic [NUM_CHAN-1:0] cnt_smp_ff;
  logic [3:0] div_ff [NUM_CHAN];
  logic [NUM_CHAN-1:0] tick_ff;
  logic [NUM_CHAN-1:0] slow;
  logic [NUM_CHAN-1:0] inc;
  logic [NUM_CHAN-1:0] ovf_set;
  count_state_t nxt_count [NUM_CHAN];
  chan_mode_t cfg [NUM_CHAN];
  logic wr_en;
  logic [7:0] rd_byte;

  function automatic logic [2:0] count_idx(int ch, logic hi);
    return 3'(int'(IDX_COUNT_BASE) + 2 * ch + int'(hi));
  endfunction : count_idx

  assign readdata = readdata_ff;
  assign waitrequest = waitrequest_ff;
  assign irq_req = ovf_ff;
  // Write lands only at the edge where waitrequest is seen low, and only with byte lane 0 enabled
  assign wr_en = write && !waitrequest_ff && byteenable[0];

  // Bus handshake: one wait cycle, then a one-cycle answer
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      waitrequest_ff <= 1'b1;
      readdata_ff <= 32'h0;
    end
    else if ((read || write) && waitrequest_ff)
    begin
      waitrequest_ff <= 1'b0;
      readdata_ff <= {24'h0, rd_byte};
    end
    else
      waitrequest_ff <= 1'b1;
  end

  always_comb
  begin
    rd_byte = 8'h00;
    if (address == IDX_CTRL)
    begin
      for (int i = 0; i < NUM_CHAN; i++)
      begin
        rd_byte[CTRL_TYPE_POS + CTRL_STRIDE * i] = type_ff[i];
        rd_byte[CTRL_EDGE_POS + CTRL_STRIDE * i] = edge_ff[i];
        rd_byte[CTRL_RUN_POS + CTRL_STRIDE * i] = run_ff[i];
        rd_byte[CTRL_OVF_POS + CTRL_STRIDE * i] = ovf_ff[i];
      end
    end
    else if (address == IDX_MODE)
      rd_byte = mode_ff;
    else if (address == IDX_CKCFG)
      rd_byte = {5'h00, ckcfg_ff};
    else
    begin
      for (int i = 0; i < NUM_CHAN; i++)
      begin
        if (address == count_idx(i, 1'b0))
          rd_byte = low_ff[i];
        if (address == count_idx(i, 1'b1))
          rd_byte = high_ff[i];
      end
    end
  end
  // Mode and clock configuration; stop the channel first
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      mode_ff <= MODE_RST;
      ckcfg_ff <= CKCFG_RST;
    end
    else if (wr_en && address == IDX_MODE)
      mode_ff <= writedata[7:0];
    else if (wr_en && address == IDX_CKCFG)
      ckcfg_ff <= writedata[2:0];
  end
  // Pin synchronisers; a level is taken once stages two and three agree
  // Idle-level reset keeps the level-type gate flag from rising after reset
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NUM_CHAN; i++)
      begin
        cnt_sync_ff[i] <= {3{PIN_IDLE}};
        gate_sync_ff[i] <= {3{PIN_IDLE}};
      end
      cnt_lvl_ff <= {NUM_CHAN{PIN_IDLE}};
      gate_lvl_ff <= {NUM_CHAN{PIN_IDLE}};
    end
    else
    begin
      for (int i = 0; i < NUM_CHAN; i++)
      begin
        cnt_sync_ff[i] <= {cnt_sync_ff[i][1:0], count_pin[i]};
        gate_sync_ff[i] <= {gate_sync_ff[i][1:0], external_gate_input[i]};
        if (cnt_sync_ff[i][1] == cnt_sync_ff[i][2])
          cnt_lvl_ff[i] <= cnt_sync_ff[i][2];
        if (gate_sync_ff[i][1] == gate_sync_ff[i][2])
          gate_lvl_ff[i] <= gate_sync_ff[i][2];
      end
    end
  end

  // Peripheral cycle tick per channel
  always_comb
  begin
    for (int i = 0; i < NUM_CHAN; i++)
    begin
      slow[i] = ckcfg_ff[i] || !ckcfg_ff[CKCFG_X2_POS];
      cfg[i] = chan_mode_t'(mode_ff[MODE_FIELD_W * i +: MODE_FIELD_W]);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NUM_CHAN; i++)
        div_ff[i] <= 4'h0;
      tick_ff <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_CHAN; i++)
        // Six timer clocks per peripheral cycle
        if (div_ff[i] >= (slow[i] ? TICK_SLOW : TICK_FAST) - 4'h1)
        begin
          div_ff[i] <= 4'h0;
          tick_ff[i] <= 1'b1;
        end
        else
        begin
          div_ff[i] <= div_ff[i] + 4'h1;
          tick_ff[i] <= 1'b0;
        end
    end
  end
  // Count pin sampled once per peripheral cycle
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cnt_smp_ff <= '0;
      gate_prev_ff <= {NUM_CHAN{PIN_IDLE}};
    end
    else
    begin
      gate_prev_ff <= gate_lvl_ff;
      for (int i = 0; i < NUM_CHAN; i++)
        if (tick_ff[i])
          cnt_smp_ff[i] <= cnt_lvl_ff[i];
    end
  end

  always_comb
  begin
    for (int i = 0; i < NUM_CHAN; i++)
    begin
      // Falling edge needs two samples, so at most one count per two cycles
      inc[i] = tick_ff[i] && run_ff[i]
        && (!cfg[i].gate_enable || gate_lvl_ff[i])
        && (cfg[i].count_src ? (cnt_smp_ff[i] && !cnt_lvl_ff[i]) : 1'b1);
      nxt_count[i] = count_step(cfg[i].mode_sel, high_ff[i], low_ff[i]);
      ovf_set[i] = inc[i] && nxt_count[i].overflow_flag;
    end
  end
  // Count bytes; a software preset wins over a count event
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NUM_CHAN; i++)
      begin
        low_ff[i] <= COUNT_RST;
        high_ff[i] <= COUNT_RST;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_CHAN; i++)
      begin
        if (inc[i])
        begin
          low_ff[i] <= nxt_count[i].count_low_byte;
          high_ff[i] <= nxt_count[i].count_high_byte;
        end
        // Presets while running are the user's hazard
        if (wr_en && address == count_idx(i, 1'b0))
          low_ff[i] <= writedata[7:0];
        if (wr_en && address == count_idx(i, 1'b1))
          high_ff[i] <= writedata[7:0];
      end
    end
  end

  // Run and interrupt type bits; setting run touches no count
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      run_ff <= CTRL_RST[NUM_CHAN-1:0];
      type_ff <= CTRL_RST[NUM_CHAN-1:0];
    end
    else if (wr_en && address == IDX_CTRL)
    begin
      for (int i = 0; i < NUM_CHAN; i++)
      begin
        run_ff[i] <= writedata[CTRL_RUN_POS + CTRL_STRIDE * i];
        type_ff[i] <= writedata[CTRL_TYPE_POS + CTRL_STRIDE * i];
      end
    end
  end
  // Overflow flags: hardware set wins over acknowledge and software clear
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      ovf_ff <= CTRL_RST[NUM_CHAN-1:0];
    else
    begin
      for (int i = 0; i < NUM_CHAN; i++)
        if (ovf_set[i])
          ovf_ff[i] <= 1'b1;
        else if (wr_en && address == IDX_CTRL)
          ovf_ff[i] <= writedata[CTRL_OVF_POS + CTRL_STRIDE * i];
        else if (irq_ack[i])
          ovf_ff[i] <= 1'b0;
    end
  end
  // External interrupt flags on the gate pin: level or falling edge
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      edge_ff <= CTRL_RST[NUM_CHAN-1:0];
    else
    begin
      for (int i = 0; i < NUM_CHAN; i++)
        if (!type_ff[i])
          edge_ff[i] <= !gate_lvl_ff[i];
        else if (gate_prev_ff[i] && !gate_lvl_ff[i])
          edge_ff[i] <= 1'b1;
        else if (wr_en && address == IDX_CTRL)
          edge_ff[i] <= writedata[CTRL_EDGE_POS + CTRL_STRIDE * i];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  property p_tick_slow;
    tick_ff[0] && slow[0] |=> (!tick_ff[0] || !slow[0])[*8];
  endproperty
  a_tick_slow: assert property (p_tick_slow) else $error("slow tick too frequent");
  property p_tick_fast;
    tick_ff[0] && !slow[0] && $stable(ckcfg_ff) |=> (!tick_ff[0])[*5] ##1 (tick_ff[0] || slow[0]);
  endproperty
  a_tick_fast: assert property (p_tick_fast) else $error("fast tick not six cycles");
  property p_run_hold;
    !run_ff[0] && !wr_en |=> $stable(low_ff[0]) && $stable(high_ff[0]);
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("count moved while stopped");
  property p_gate_hold;
    cfg[0].gate_enable && !gate_lvl_ff[0] && !wr_en |=> $stable(low_ff[0]);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("count moved with gate low");
  property p_ovf13;
    inc[0] && cfg[0].mode_sel == MODE_13BIT && high_ff[0] == 8'hff && low_ff[0][4:0] == 5'h1f
      |=> ovf_ff[0] && high_ff[0] == 8'h00 && low_ff[0][4:0] == 5'h00;
  endproperty
  a_ovf13: assert property (p_ovf13) else $error("mode 0 rollover wrong");
  property p_prescale;
    inc[0] && !wr_en && cfg[0].mode_sel == MODE_13BIT && low_ff[0][4:0] != 5'h1f
      |=> low_ff[0][4:0] == $past(low_ff[0][4:0]) + 5'h01 && $stable(high_ff[0])
        && $stable(low_ff[0][7:5]);
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescaler step wrong");
  property p_ext_edge;
    inc[0] && cfg[0].count_src |-> cnt_smp_ff[0] && !cnt_lvl_ff[0] && tick_ff[0];
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("pin count without fall");
  property p_ack_clear;
    irq_ack[0] && !ovf_set[0] && !(wr_en && address == IDX_CTRL) |=> !ovf_ff[0];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("ack left overflow set");
  property p_set_wins;
    ovf_set[1] |=> ovf_ff[1];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("overflow event lost");
  property p_wait;
    (read || write) && waitrequest_ff |=> !waitrequest_ff ##1 waitrequest_ff;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer timing wrong");

  c_ovf: cover property (ovf_set[0]);
  c_ext: cover property (inc[1] && cfg[1].count_src);
  c_read: cover property (read && !waitrequest_ff && address == IDX_CTRL);
endmodule : dual_timer_counter_core
`default_nettype wire

// *** bench/pin_source.sv ***
// Purpose: Far side model driving count and gate pins of both channels
// Assumes: Levels change just after a rising clock edge
// Notes: Count pins idle high so a pulse is one falling then one rising edge
`timescale 1ns/1ns
`default_nettype none
module pin_source (
  input wire logic clk,
  output logic [1:0] count_pin,
  output logic [1:0] external_gate_input
);
  initial
  begin
    count_pin = 2'b11;
    external_gate_input = 2'b11;
  end

  task set_gate(input int ch, input logic lvl);
    @(posedge clk);
    external_gate_input[ch] <= lvl;
  endtask : set_gate

  // Each level held past one peripheral cycle so no sample is missed
  task pulse(input int ch, input int cnt, input int hold);
    repeat (cnt)
    begin
      @(posedge clk);
      count_pin[ch] <= 1'b0;
      repeat (hold) @(posedge clk);
      count_pin[ch] <= 1'b1;
      repeat (hold) @(posedge clk);
    end
  endtask : pulse
endmodule : pin_source
`default_nettype wire

// *** bench/dual_timer_counter_core_tb.sv ***
// Purpose: Self-checking bench for the dual timer/counter core
// Assumes: Fixed one wait cycle per access, but waits are bounded anyway
// Notes: Tick phase is free running, so timed counts are checked in ranges
`timescale 1ns/1ns
`default_nettype none
module dual_timer_counter_core_tb;
  import timer_pkg::*;
  logic clk;
  logic reset_n;
  logic [2:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [3:0] byteenable;
  logic [31:0] readdata;
  logic waitrequest;
  logic [NUM_CHAN-1:0] count_pin;
  logic [NUM_CHAN-1:0] external_gate_input;
  logic [NUM_CHAN-1:0] irq_ack;
  logic [NUM_CHAN-1:0] irq_req;
  logic [31:0] rd;
  logic [7:0] keep;
  logic [7:0] cfg [4] = '{8'h00, 8'h04, 8'h05, 8'h06};
  logic fast [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  int bad_count;
  int comparisons;
  int n;

  dual_timer_counter_core dut (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .count_pin(count_pin),
    .external_gate_input(external_gate_input), .irq_ack(irq_ack), .irq_req(irq_req));

  pin_source pins (.clk(clk), .count_pin(count_pin),
    .external_gate_input(external_gate_input));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task end_sim;
    $display("Compared %0d, mismatched %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    comparisons++;
    if ($isunknown(got) || got < lo || got > hi)
    begin
      bad_count++;
      $display("[ERR] %0t got %h outside %h..%h", $time, got, lo, hi);
    end
  endtask : chk_rng

  // Request held until waitrequest is seen low at a rising edge
  task bus(input logic wr, input logic [2:0] a, input logic [7:0] d, input logic [3:0] be);
    int k;
    @(posedge clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= {24'h000000, d};
    byteenable <= be;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (waitrequest !== 1'b0 && k < 20);
    if (k >= 20)
    begin
      bad_count++;
      $display("[ERR] %0t bus answer missing", $time);
      end_sim;
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask : wr

  task rdchk(input logic [2:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 4'h1);
    chk(rd, {24'h000000, exp});
  endtask : rdchk

  initial
  begin
    reset_n = 1'b0;
    address = 3'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    byteenable = 4'h1;
    irq_ack = 2'h0;
    bad_count = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (n = 0; n < 8; n++)
      rdchk(n[2:0], 8'h00);
    wr(3'h7, 8'h5a);
    rdchk(3'h7, 8'h00);
    bus(1'b1, 3'h3, 8'hff, 4'h0);
    rdchk(3'h3, 8'h00);
    $display("Test reset and map done");

    wr(3'h3, 8'hfe);
    wr(3'h4, 8'hff);
    rdchk(3'h3, 8'hfe);
    wr(3'h0, 8'h10);
    n = 0;
    while (irq_req[0] !== 1'b1 && n < 60)
    begin
      @(posedge clk);
      n++;
    end
    chk_rng(n[7:0], 8'h0b, 8'h1b);
    rdchk(3'h0, 8'h30);
    wr(3'h0, 8'h20);
    rdchk(3'h4, 8'h00);
    bus(1'b0, 3'h3, 8'h00, 4'h1);
    chk_rng({3'b000, rd[4:0]}, 8'h00, 8'h02);
    @(posedge clk);
    irq_ack <= 2'h1;
    @(posedge clk);
    irq_ack <= 2'h0;
    repeat (2) @(posedge clk);
    chk({31'h0, irq_req[0]}, 32'h0);
    rdchk(3'h0, 8'h00);
    bus(1'b0, 3'h3, 8'h00, 4'h1);
    keep = rd[7:0];
    repeat (40) @(posedge clk);
    rdchk(3'h3, keep);
    $display("Test overflow done");

    wr(3'h3, 8'h00);
    wr(3'h1, 8'h08);
    pins.set_gate(0, 1'b0);
    // Let the low gate level through the synchroniser before run is set
    repeat (6) @(posedge clk);
    wr(3'h0, 8'h10);
    repeat (60) @(posedge clk);
    rdchk(3'h3, 8'h00);
    pins.set_gate(0, 1'b1);
    repeat (60) @(posedge clk);
    wr(3'h0, 8'h00);
    bus(1'b0, 3'h3, 8'h00, 4'h1);
    chk_rng(rd[7:0], 8'h03, 8'h06);
    $display("Test gating done");

    // Mode 0 written again on each pass; each config counts for about 123 cycles
    for (n = 0; n < 4; n++)
    begin
      wr(3'h1, 8'h00);
      wr(3'h2, cfg[n]);
      wr(3'h3, 8'h00);
      wr(3'h0, 8'h10);
      repeat (120) @(posedge clk);
      wr(3'h0, 8'h00);
      bus(1'b0, 3'h3, 8'h00, 4'h1);
      chk_rng(rd[7:0], fast[n] ? 8'h13 : 8'h09, fast[n] ? 8'h16 : 8'h0b);
    end
    $display("Test clock rates done");

    wr(3'h2, 8'h00);
    wr(3'h1, 8'h40);
    // Four counts short of rollover, so the fourth of five falls overflows channel 1
    wr(3'h5, 8'hfc);
    wr(3'h6, 8'hff);
    wr(3'h0, 8'h40);
    pins.pulse(1, 5, 14);
    repeat (30) @(posedge clk);
    chk({31'h0, irq_req[1]}, 32'h1);
    wr(3'h0, 8'h00);
    bus(1'b0, 3'h5, 8'h00, 4'h1);
    chk({27'h0, rd[4:0]}, 32'h1);
    chk({29'h0, rd[7:5]}, 32'h7);
    rdchk(3'h6, 8'h00);
    $display("Test counter mode done");
    end_sim;
  end

  initial
  begin
    repeat (100000) @(posedge clk);
    bad_count++;
    $display("[ERR] %0t run timeout", $time);
    end_sim;
  end
endmodule : dual_timer_counter_core_tb
`default_nettype wire
